// File: tb/branch_skip_unit_sva.sv
// Purpose: port checks for the branch and skip unit
// Assumes: one clock, synchronous active-low reset
// Notes: targets are checked one cycle after the accepting edge
module branch_skip_unit_chk
    import branch_skip_pkg::*;
#(
    parameter int PC_W = 16,
    parameter int OFS_W = 7
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic issue,
    input wire op_t op,
    input wire logic [PC_W-1:0] pc_in,
    input wire logic [OFS_W-1:0] offset,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] status_flags,
    input wire logic [7:0] reg_value,
    input wire logic [7:0] io_value,
    input wire logic next_is_two_word,
    input wire logic [PC_W-1:0] pc_out,
    input wire logic pc_load,
    input wire logic taken,
    input wire logic busy,
    input wire logic done
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Derived request terms, sampled through $past below
    wire logic acc = issue && !busy && op != op_none;
    wire logic skp = op inside {skip_reg_bit_set, skip_io_bit_clear, skip_io_bit_set};
    wire logic long_skp = skp && next_is_two_word;
    wire logic reg_bit = reg_value[bit_sel];
    wire logic [PC_W-1:0] ofs_ext = {{(PC_W-OFS_W){offset[OFS_W-1]}}, offset};
    wire logic [PC_W-1:0] skip_len = PC_W'(next_is_two_word ? 3 : 2);
    a_issue_loads: assert property (acc |=> pc_load) else $error("no load after issue");
    a_load_cause: assert property (pc_load |-> $past(acc)) else $error("load without issue");
    a_step_pc: assert property (pc_load && !taken |-> pc_out == $past(pc_in) + 1'b1 && done)
        else $error("bad sequential pc");
    a_branch_pc: assert property (pc_load && taken && !$past(skp) |->
        pc_out == $past(pc_in) + $past(ofs_ext) + 1'b1) else $error("bad branch target");
    a_skip_pc: assert property (pc_load && taken && $past(skp) |->
        pc_out == $past(pc_in) + $past(skip_len)) else $error("bad skip target");
    a_two_cycle: assert property (pc_load && taken && !$past(long_skp) |->
        busy && !done ##1 done && !busy) else $error("bad two cycle timing");
    a_three_cycle: assert property (pc_load && taken && $past(long_skp) |->
        (busy && !done) [*2] ##1 done && !busy) else $error("bad three cycle timing");
    a_reg_bit_test: assert property (pc_load && $past(op) == skip_reg_bit_set |->
        taken == $past(reg_bit)) else $error("bad register bit test");
endmodule

bind branch_skip_unit branch_skip_unit_chk #(.PC_W(PC_W), .OFS_W(OFS_W)) chk_i (
    .mclk(mclk),
    .reset_n(reset_n),
    .issue(issue),
    .op(op),
    .pc_in(pc_in),
    .offset(offset),
    .bit_sel(bit_sel),
    .status_flags(status_flags),
    .reg_value(reg_value),
    .io_value(io_value),
    .next_is_two_word(next_is_two_word),
    .pc_out(pc_out),
    .pc_load(pc_load),
    .taken(taken),
    .busy(busy),
    .done(done)
);

// File: tb/tb.sv
// Purpose: random self-checking run of the branch and skip unit
// Assumes: inputs change at the falling edge
// Notes: issue stays high, so requests during busy are always refused
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import branch_skip_pkg::*;
    logic mclk = 0, reset_n = 0, issue = 0, next_is_two_word = 0, pc_load, taken, busy, done, xt, skp;
    op_t op = op_none;
    logic [15:0] pc_in = 0, pc_out, xpc;
    logic [6:0] offset = 0;
    logic [2:0] bit_sel = 0;
    logic [7:0] status_flags = 0, reg_value = 0, io_value = 0;
    int err_total = 0, tests_run = 0, seed = 36, n, xn;
    int model_q[$];
    branch_skip_unit branch_skip_unit_i (
        .mclk(mclk),
        .reset_n(reset_n),
        .issue(issue),
        .op(op),
        .pc_in(pc_in),
        .offset(offset),
        .bit_sel(bit_sel),
        .status_flags(status_flags),
        .reg_value(reg_value),
        .io_value(io_value),
        .next_is_two_word(next_is_two_word),
        .pc_out(pc_out),
        .pc_load(pc_load),
        .taken(taken),
        .busy(busy),
        .done(done)
    );
    // Core clock, 25 ns period
    always #12.5 mclk = ~mclk;
    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'h1) begin
            err_total++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Reference condition, kept apart from the design's evaluator
    function automatic logic cond_of(op_t o, logic [7:0] f, r, p, logic [2:0] b);
        case (o)
            skip_reg_bit_set: return r[b];
            skip_io_bit_clear: return !p[b];
            skip_io_bit_set: return p[b];
            branch_flag_set: return f[b];
            branch_flag_clear: return !f[b];
            branch_equal: return f[1];
            branch_not_equal: return !f[1];
            branch_carry_set, branch_lower: return f[0];
            branch_carry_clear, branch_same_or_higher: return !f[0];
            branch_minus: return f[2];
            branch_plus: return !f[2];
            branch_signed_ge: return !(f[2] ^ f[3]);
            branch_signed_lt: return f[2] ^ f[3];
            branch_half_carry_set: return f[5];
            branch_half_carry_clear: return !f[5];
            default: return f[6];
        endcase
    endfunction
    // Every op in turn with random operands, back to back
    initial begin
        repeat (20) @(negedge mclk);
        check(pc_out === 16'h0000 && pc_load === 1'b0 && busy === 1'b0 && done === 1'b0, "reset values");
        reset_n = 1;
        for (int i = 0; i < 380; i++) begin
            op = op_t'(i % 19);
            {status_flags, reg_value, io_value} = 24'($random(seed));
            {pc_in, offset, bit_sel, next_is_two_word} = 27'($random(seed));
            issue = 1;
            xt = cond_of(op, status_flags, reg_value, io_value, bit_sel);
            skp = op inside {skip_reg_bit_set, skip_io_bit_clear, skip_io_bit_set};
            xpc = pc_in + 16'h0001;
            if (xt)
                xpc = skp ? pc_in + (next_is_two_word ? 16'h0003 : 16'h0002) : xpc + {{9{offset[6]}}, offset};
            xn = !xt ? 1 : (skp && next_is_two_word) ? 3 : 2;
            model_q.push_back(int'(xpc));
            @(negedge mclk);
            xpc = 16'(model_q.pop_front());
            if (op == op_none) begin
                check(pc_load === 1'b0, "load on op_none");
            end else begin
                check(pc_load === 1'b1 && pc_out === xpc && taken === xt, "target or condition");
                check(busy === (xn > 1), "busy level");
                n = 1;
                while (done !== 1'b1 && n < 6) begin
                    @(negedge mclk);
                    n++;
                    check(pc_load === 1'b0, "load while busy");
                end
                check(n == xn, "cycle count");
                if (done !== 1'b1)
                    break;
            end
            $display("test %0d ends", i);
        end
        print_verdict();
    end
endmodule

// File: verilog/branch_cond_eval.sv
// Purpose: combinational condition test for branches and skips
// Assumes: flags and operands are stable for the issue cycle
// Notes: pure logic, no state; flags are only read, never written
`include "branch_skip_regs.svh"
module branch_cond_eval
    import branch_skip_pkg::*;
(
    input wire op_t op,
    input wire logic [7:0] status_flags,
    input wire logic [7:0] reg_value,
    input wire logic [7:0] io_value,
    input wire logic [2:0] bit_sel,
    output logic is_skip,
    output logic is_branch,
    output logic cond_true
);
    // Condition per operation, from a status flag, a register bit or an I/O bit
    always_comb begin
        is_skip = 1'h0;
        is_branch = 1'h1;
        cond_true = 1'h0;
        unique case (op)
            op_none: is_branch = 1'h0;
            skip_reg_bit_set: begin
                is_skip = 1'h1;
                is_branch = 1'h0;
                cond_true = reg_value[bit_sel];
            end
            skip_io_bit_clear: begin
                is_skip = 1'h1;
                is_branch = 1'h0;
                cond_true = ~io_value[bit_sel];
            end
            skip_io_bit_set: begin
                is_skip = 1'h1;
                is_branch = 1'h0;
                cond_true = io_value[bit_sel];
            end
            branch_flag_set: cond_true = status_flags[bit_sel];
            branch_flag_clear: cond_true = ~status_flags[bit_sel];
            branch_equal: cond_true = status_flags[`FLAG_Z];
            branch_not_equal: cond_true = ~status_flags[`FLAG_Z];
            branch_carry_set, branch_lower: cond_true = status_flags[`FLAG_C];
            branch_carry_clear: cond_true = ~status_flags[`FLAG_C];
            branch_same_or_higher: cond_true = ~status_flags[`FLAG_C];
            branch_minus: cond_true = status_flags[`FLAG_N];
            branch_plus: cond_true = ~status_flags[`FLAG_N];
            branch_signed_ge: cond_true = ~(status_flags[`FLAG_N] ^ status_flags[`FLAG_V]);
            branch_signed_lt: cond_true = status_flags[`FLAG_N] ^ status_flags[`FLAG_V];
            branch_half_carry_set: cond_true = status_flags[`FLAG_H];
            branch_half_carry_clear: cond_true = ~status_flags[`FLAG_H];
            branch_transfer_bit_set: cond_true = status_flags[`FLAG_T];
            default: is_branch = 1'h0; // Unused codes are not of this group
        endcase
    end
endmodule

// File: verilog/branch_skip_pkg.sv
// Purpose: types for the conditional branch and skip unit
// Assumes: operation code is decoded upstream into op_t
// Notes: op_none means the instruction is not of this group
package branch_skip_pkg;
    typedef enum logic [4:0] {
        op_none,
        skip_reg_bit_set,
        skip_io_bit_clear,
        skip_io_bit_set,
        branch_flag_set,
        branch_flag_clear,
        branch_equal,
        branch_not_equal,
        branch_carry_set,
        branch_carry_clear,
        branch_same_or_higher,
        branch_lower,
        branch_minus,
        branch_plus,
        branch_signed_ge,
        branch_signed_lt,
        branch_half_carry_set,
        branch_half_carry_clear,
        branch_transfer_bit_set
    } op_t;
endpackage

// File: verilog/branch_skip_regs.svh
// Purpose: constants for the conditional branch and skip unit
// Assumes: 16-bit word program counter, 8-bit status flags, one clock
// Notes: flag positions follow the usual I T H S V N Z C layout
`ifndef BRANCH_SKIP_REGS_SVH
`define BRANCH_SKIP_REGS_SVH
`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_S 3'h4
`define FLAG_H 3'h5
`define FLAG_T 3'h6
`define FLAG_I 3'h7
`define PC_RESET 16'h0000
`define PC_STEP 16'h0001
`define PC_SKIP1 16'h0002
`define PC_SKIP2 16'h0003
`define CYC_ONE 2'h1
`define CYC_TWO 2'h2
`define CYC_THREE 2'h3
`define WAIT_DONE 2'h0
`define WAIT_STEP 2'h1
`endif

// File: verilog/branch_skip_unit.sv
// Purpose: program counter update and cycle timing for conditional branches and skips
// Assumes: issue may stay high until done; an issue while busy is high is ignored
// Notes: status flags are inputs only, so this unit cannot alter them
// Notes: every result except done of a taken instruction shows on the accepting edge, straight from a register
// Notes: pc arithmetic wraps modulo the program counter width
// Notes: one always_ff per register concern, so each output has a single owner
`include "branch_skip_regs.svh"
module branch_skip_unit
    import branch_skip_pkg::*;
#(
    parameter int PC_W = 16,
    parameter int OFS_W = 7
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic issue,
    input wire op_t op,
    input wire logic [PC_W-1:0] pc_in,
    input wire logic [OFS_W-1:0] offset,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] status_flags,
    input wire logic [7:0] reg_value,
    input wire logic [7:0] io_value,
    input wire logic next_is_two_word,
    output logic [PC_W-1:0] pc_out,
    output logic pc_load,
    output logic taken,
    output logic busy,
    output logic done
);
    // Controller states: st_wait holds every cycle after the first one of a taken instruction
    typedef enum logic [1:0] {st_idle, st_wait} state_t;

    // Sequencing state
    state_t state_r;
    logic [1:0] wait_r;

    // Registered results; the output ports are plain copies of these
    logic [PC_W-1:0] pc_r;
    logic load_r;
    logic taken_r;
    logic busy_r;
    logic done_r;

    // Evaluator results for the operation presented this cycle
    logic is_skip;
    logic is_branch;
    logic cond_true;

    // Decoded request terms and next values
    logic accept;
    logic start_wait;
    logic [1:0] cycles;
    logic [1:0] wait_nxt;
    logic [PC_W-1:0] pc_nxt;

    // Sign-extend the word displacement; k counts words, so it is added unshifted
    function automatic logic [PC_W-1:0] sext_ofs(input logic [OFS_W-1:0] k);
        return {{(PC_W-OFS_W){k[OFS_W-1]}}, k};
    endfunction

    // Target of a taken relative branch: pc + k + 1, wrapping at the top of program memory
    function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] pc, input logic [OFS_W-1:0] k);
        return pc + sext_ofs(k) + PC_W'(`PC_STEP);
    endfunction

    // Address past the skipped instruction; a two-word follower needs one word more
    function automatic logic [PC_W-1:0] skip_target(input logic [PC_W-1:0] pc, input logic two_word);
        return pc + (two_word ? PC_W'(`PC_SKIP2) : PC_W'(`PC_SKIP1));
    endfunction

    // Total cycles of one instruction of the group, issue cycle included;
    // only a met condition costs more than one
    function automatic logic [1:0] cycle_count(input logic skip, input logic cond, input logic two_word);
        logic [1:0] n;
        if (!cond)
            n = `CYC_ONE;
        else if (skip && two_word)
            n = `CYC_THREE;
        else
            n = `CYC_TWO;
        return n;
    endfunction

    // Condition test; kept apart so the decode can be reused by a later pipeline stage
    // without pulling in the counter logic
    branch_cond_eval u_eval (
        .op(op),
        .status_flags(status_flags),
        .reg_value(reg_value),
        .io_value(io_value),
        .bit_sel(bit_sel),
        .is_skip(is_skip),
        .is_branch(is_branch),
        .cond_true(cond_true)
    );

    // Accept only from idle; an issue during the extra cycles is dropped, not queued
    assign accept = (state_r == st_idle) && issue && (is_skip || is_branch);

    // Only a met condition leads into wait states
    assign start_wait = accept && cond_true;

    // Cycles of the presented instruction
    assign cycles = cycle_count(is_skip, cond_true, next_is_two_word);

    // The first wait cycle is st_wait itself, so the counter holds only the cycles beyond it;
    // for a failed condition the value is meaningless and is never loaded
    assign wait_nxt = cycles - `CYC_TWO;

    // New pc: relative target, skip distance, or next word;
    // the flags are read here and nowhere written
    always_comb begin
        if (is_branch && cond_true)
            pc_nxt = rel_target(pc_in, offset);
        else if (is_skip && cond_true)
            pc_nxt = skip_target(pc_in, next_is_two_word);
        else
            pc_nxt = pc_in + PC_W'(`PC_STEP);
    end

    // Timing of one instruction, counted from the accepting edge:
    //   condition false: pc_load and done together, one cycle in all
    //   taken branch or one-word skip: busy for one cycle, then done
    //   two-word skip: busy for two cycles, then done
    // The caller keeps its request parked until done; an issue seen while busy is ignored,
    // which is cheaper than a request queue and matches a core that stalls its fetch.
    // Controller state; a taken instruction parks in st_wait until its last cycle
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_r <= st_idle;
        end else begin
            unique case (state_r)
                st_idle: begin
                    if (start_wait)
                        state_r <= st_wait;
                end
                st_wait: begin
                    if (wait_r == `WAIT_DONE)
                        state_r <= st_idle;
                end
            endcase
        end
    end

    // Extra cycle counter: loaded on a taken issue, counted down in st_wait;
    // it rests at zero so a stray wait state can never run long
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wait_r <= `WAIT_DONE;
        end else if (start_wait) begin
            wait_r <= wait_nxt;
        end else if (state_r == st_wait && wait_r != `WAIT_DONE) begin
            wait_r <= wait_r - `WAIT_STEP;
        end
    end

    // Busy covers every cycle after the issue cycle of a taken instruction;
    // it falls on the same edge as done rises, so the next issue may follow at once
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            busy_r <= 1'h0;
        end else if (start_wait) begin
            busy_r <= 1'h1;
        end else if (state_r == st_wait && wait_r == `WAIT_DONE) begin
            busy_r <= 1'h0;
        end
    end

    // Done marks the last cycle: at once when the condition fails,
    // otherwise when the wait counter has run out
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            done_r <= 1'h0;
        end else if (state_r == st_idle) begin
            done_r <= accept && !cond_true;
        end else begin
            done_r <= (wait_r == `WAIT_DONE);
        end
    end

    // New pc is captured on the accepting edge and stands until the next accepted issue;
    // a refused issue leaves it alone
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pc_r <= PC_W'(`PC_RESET);
        end else if (accept) begin
            pc_r <= pc_nxt;
        end
    end

    // Load strobe: one cycle, on the edge after acceptance, for every instruction
    // of the group, taken or not, so the fetch side never has to infer pc + 1
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            load_r <= 1'h0;
        end else begin
            load_r <= accept;
        end
    end

    // Condition result of the last accepted instruction;
    // held as a level so a slow consumer can still read it after done
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            taken_r <= 1'h0;
        end else if (accept) begin
            taken_r <= cond_true;
        end
    end

    // Flags are inputs only: there is no path back into the status register,
    // so every instruction of the group leaves the flags as they were
    // Outputs straight from their registers
    assign pc_out = pc_r;
    assign pc_load = load_r;
    assign taken = taken_r;
    assign busy = busy_r;
    assign done = done_r;
endmodule
